/* pkg/xb_consts.svh */
/*
  constants for the expansion-bus master: widths, control codes, timing.
  assumes a 50 MHz logic clock and a clockless bus sampled through flops.
*/
`ifndef XB_CONSTS_SVH
`define XB_CONSTS_SVH

`define XB_ADDR_W 18
`define XB_DATA_W 16
`define XB_CTL_W 2
`define XB_WORDS_W 8

// transfer type codes on the control lines
`define XB_CTL_READ 2'h0
`define XB_CTL_IDLE 2'h0
// address step between words, in bytes
`define XB_ADDR_STEP 18'h00002

`define XB_CLK_PERIOD_NS 20
// settling and decode time before the strobe
`define XB_SETTLE_NS 150
// skew allowance between acknowledge and data
`define XB_SKEW_NS 100
// hold of address and control after the strobe drops
`define XB_HOLD_NS 100
// arbiter gives up a grant left unanswered this long
`define XB_GRANT_TMO_NS 5000
// least times: round up to whole cycles
`define XB_SETTLE_CYC ((`XB_SETTLE_NS + `XB_CLK_PERIOD_NS - 1) / `XB_CLK_PERIOD_NS)
`define XB_SKEW_CYC ((`XB_SKEW_NS + `XB_CLK_PERIOD_NS - 1) / `XB_CLK_PERIOD_NS)
`define XB_HOLD_CYC ((`XB_HOLD_NS + `XB_CLK_PERIOD_NS - 1) / `XB_CLK_PERIOD_NS)
`define XB_GRANT_TMO_CYC (`XB_GRANT_TMO_NS / `XB_CLK_PERIOD_NS)
`define XB_CNT_W 4

`endif

/* pkg/xb_pkg.sv */
/*
  types for the expansion-bus master.
  assumes xb_consts.svh is on the include path.
*/
`include "xb_consts.svh"
package xb_pkg;

  typedef enum logic [1:0] {
    XB_KIND_READ = 2'h0,
    XB_KIND_INTERRUPT_REQUEST_LINE = 2'h1,
    XB_KIND_READ_INTERRUPT_REQUEST_LINE = 2'h2
  } xb_kind_e;

  typedef struct packed {
    xb_kind_e kind;
    logic [`XB_ADDR_W-1:0] addr;
    logic [`XB_WORDS_W-1:0] words;
    logic [`XB_DATA_W-1:0] vector;
  } xb_cmd_s;

  typedef enum logic [3:0] {
    XB_ST_IDLE = 4'h0,
    XB_ST_REQ = 4'h1,
    XB_ST_WAIT_BUS = 4'h2,
    XB_ST_SETTLE = 4'h3,
    XB_ST_STROBE = 4'h4,
    XB_ST_SKEW = 4'h5,
    XB_ST_WAIT_DROP = 4'h6,
    XB_ST_HOLD = 4'h7,
    XB_ST_INTERRUPT_REQUEST_LINE = 4'h8
  } xb_state_e;

endpackage

/* src/xb_sync.sv */
/*
  three-flop input synchroniser; output follows once stages two and
  three agree. assumes one clock, synchronous active-high reset.
*/
module xb_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // asynchronous input and its clean copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else if (s2_reg == s3_reg) begin
      q <= s3_reg;
    end
  end
endmodule

/* src/xb_master.sv */
/*
  bus master device: wins the bus by priority request, runs multi-word
  read transfers and one vectored interrupt per tenure.
  assumes processor, arbiter and slaves keep their side of the handshake.
*/
`include "xb_consts.svh"
module xb_master #(
  parameter int SETTLE_CYC = `XB_SETTLE_CYC,
  parameter int SKEW_CYC = `XB_SKEW_CYC,
  parameter int HOLD_CYC = `XB_HOLD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // command port
  input wire logic cmd_valid,
  input wire xb_pkg::xb_cmd_s cmd,
  output logic cmd_ready,
  output logic [`XB_DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic done,
  // arbitration pins
  output logic priority_bus_request,
  input wire logic priority_bus_grant,
  output logic selection_acknowledge,
  output logic bus_busy,
  input wire logic bus_busy_in,
  // transfer pins
  output logic [`XB_ADDR_W-1:0] bus_addr,
  output logic [`XB_CTL_W-1:0] bus_ctl,
  output logic master_strobe,
  input wire logic slave_acknowledge,
  output logic interrupt_request_line,
  input wire logic [`XB_DATA_W-1:0] data_in,
  output logic [`XB_DATA_W-1:0] data_out,
  output logic data_oe_n
);
  xb_pkg::xb_state_e state_reg;
  xb_pkg::xb_cmd_s cmd_reg;
  logic [`XB_WORDS_W-1:0] left_reg;
  logic [`XB_CNT_W-1:0] cnt_reg;
  logic grant_s;
  logic busy_s;
  logic ack_s;
  logic [`XB_DATA_W-1:0] data_s;
  logic cnt_zero;
  logic want_interrupt_request_line;

  xb_sync #(.W(3)) u_sync_ctl (
    .clk(clk),
    .reset(reset),
    .d({priority_bus_grant, bus_busy_in, slave_acknowledge}),
    .q({grant_s, busy_s, ack_s})
  );

  xb_sync #(.W(`XB_DATA_W)) u_sync_data (
    .clk(clk),
    .reset(reset),
    .d(data_in),
    .q(data_s)
  );

  assign cnt_zero = (cnt_reg == '0);
  assign want_interrupt_request_line = (cmd_reg.kind != xb_pkg::XB_KIND_READ);

  // sequencer and bus pins
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= xb_pkg::XB_ST_IDLE;
      cmd_reg <= '0;
      left_reg <= '0;
      cnt_reg <= '0;
      cmd_ready <= 1'b0;
      priority_bus_request <= 1'b0;
      selection_acknowledge <= 1'b0;
      bus_busy <= 1'b0;
      bus_addr <= '0;
      bus_ctl <= `XB_CTL_IDLE;
      master_strobe <= 1'b0;
      interrupt_request_line <= 1'b0;
      data_out <= '0;
      data_oe_n <= 1'b1;
    end else begin
      case (state_reg)
        xb_pkg::XB_ST_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            cmd_reg <= cmd;
            left_reg <= cmd.words;
            priority_bus_request <= 1'b1;
            state_reg <= xb_pkg::XB_ST_REQ;
          end
        end
        xb_pkg::XB_ST_REQ: begin
          if (grant_s) begin
            selection_acknowledge <= 1'b1;
            priority_bus_request <= 1'b0;
            state_reg <= xb_pkg::XB_ST_WAIT_BUS;
          end
        end
        xb_pkg::XB_ST_WAIT_BUS: begin
          if (!grant_s && !busy_s && !ack_s) begin
            bus_busy <= 1'b1;
            if (cmd_reg.kind == xb_pkg::XB_KIND_INTERRUPT_REQUEST_LINE ||
                left_reg == '0) begin
              selection_acknowledge <= 1'b0;
              interrupt_request_line <= 1'b1;
              data_out <= cmd_reg.vector;
              data_oe_n <= 1'b0;
              state_reg <= xb_pkg::XB_ST_INTERRUPT_REQUEST_LINE;
            end else begin
              bus_addr <= cmd_reg.addr;
              bus_ctl <= `XB_CTL_READ;
              data_oe_n <= 1'b1;
              if (left_reg == 8'h01 && !want_interrupt_request_line) begin
                selection_acknowledge <= 1'b0;
              end
              cnt_reg <= `XB_CNT_W'(SETTLE_CYC);
              state_reg <= xb_pkg::XB_ST_SETTLE;
            end
          end
        end
        xb_pkg::XB_ST_SETTLE: begin
          if (cnt_zero) begin
            master_strobe <= 1'b1;
            state_reg <= xb_pkg::XB_ST_STROBE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        xb_pkg::XB_ST_STROBE: begin
          if (ack_s) begin
            cnt_reg <= `XB_CNT_W'(SKEW_CYC);
            state_reg <= xb_pkg::XB_ST_SKEW;
          end
        end
        xb_pkg::XB_ST_SKEW: begin
          if (cnt_zero) begin
            master_strobe <= 1'b0;
            state_reg <= xb_pkg::XB_ST_WAIT_DROP;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        xb_pkg::XB_ST_WAIT_DROP: begin
          if (!ack_s) begin
            cnt_reg <= `XB_CNT_W'(HOLD_CYC);
            left_reg <= left_reg - 1'b1;
            state_reg <= xb_pkg::XB_ST_HOLD;
          end
        end
        xb_pkg::XB_ST_HOLD: begin
          if (!cnt_zero) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (left_reg != '0) begin
            bus_addr <= bus_addr + `XB_ADDR_STEP;
            if (left_reg == 8'h01 && !want_interrupt_request_line) begin
              selection_acknowledge <= 1'b0;
            end
            cnt_reg <= `XB_CNT_W'(SETTLE_CYC);
            state_reg <= xb_pkg::XB_ST_SETTLE;
          end else if (want_interrupt_request_line) begin
            bus_addr <= '0;
            bus_ctl <= `XB_CTL_IDLE;
            selection_acknowledge <= 1'b0;
            interrupt_request_line <= 1'b1;
            data_out <= cmd_reg.vector;
            data_oe_n <= 1'b0;
            state_reg <= xb_pkg::XB_ST_INTERRUPT_REQUEST_LINE;
          end else begin
            bus_addr <= '0;
            bus_ctl <= `XB_CTL_IDLE;
            bus_busy <= 1'b0;
            state_reg <= xb_pkg::XB_ST_IDLE;
          end
        end
        xb_pkg::XB_ST_INTERRUPT_REQUEST_LINE: begin
          if (ack_s) begin
            interrupt_request_line <= 1'b0;
            data_oe_n <= 1'b1;
            data_out <= '0;
            bus_busy <= 1'b0;
            state_reg <= xb_pkg::XB_ST_IDLE;
          end
        end
        default: begin
          state_reg <= xb_pkg::XB_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (state_reg == xb_pkg::XB_ST_SKEW && cnt_zero) begin
        rd_data <= data_s;
        rd_valid <= 1'b1;
      end
    end
  end

  // end of tenure pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      done <= 1'b0;
    end else begin
      done <= (state_reg == xb_pkg::XB_ST_INTERRUPT_REQUEST_LINE && ack_s) ||
              (state_reg == xb_pkg::XB_ST_HOLD && cnt_zero &&
               left_reg == '0 && !want_interrupt_request_line);
    end
  end
endmodule

/* test/xb_master_asserts.sv */
/*
  pin assertions for the bus master.
  assumes a bind into xb_master and one clock.
*/
`include "xb_consts.svh"
module xb_master_asserts #(
  parameter int SETTLE_CYC = 8,
  parameter int SKEW_CYC = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins
  input wire logic priority_bus_grant,
  input wire logic selection_acknowledge,
  input wire logic bus_busy,
  input wire logic [`XB_ADDR_W-1:0] bus_addr,
  input wire logic [`XB_CTL_W-1:0] bus_ctl,
  input wire logic master_strobe,
  input wire logic slave_acknowledge,
  input wire logic interrupt_request_line,
  input wire logic data_oe_n
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);

  a_read_undriven: assert property (
    master_strobe |-> data_oe_n) else $error("data driven in read");
  a_read_ctl: assert property (
    master_strobe |-> bus_ctl == `XB_CTL_READ) else $error("bad read code");
  a_strobe_skew: assert property (
    $fell(master_strobe) |-> $past(slave_acknowledge, SKEW_CYC + 1))
    else $error("strobe dropped early");
  a_word_settle: assert property (
    $rose(master_strobe) |-> $past(bus_addr, SETTLE_CYC) == bus_addr)
    else $error("strobe before settle");
  a_addr_qualified: assert property (
    $changed(bus_addr) |-> !master_strobe && !$past(master_strobe))
    else $error("address moved under strobe");
  a_interrupt_request_line_start: assert property (
    $rose(interrupt_request_line) |-> bus_busy && !selection_acknowledge
      && !data_oe_n) else $error("bad interrupt start");
  a_interrupt_request_line_release: assert property (
    $fell(interrupt_request_line) |-> data_oe_n
      && $past(slave_acknowledge, 2) ##[0:8] !bus_busy)
    else $error("bad interrupt release");
  a_one_interrupt_request_line: assert property (
    $fell(interrupt_request_line) |=> !interrupt_request_line [*8])
    else $error("second interrupt in tenure");
  a_sync_grant: assert property (
    $rose(selection_acknowledge) |-> $past(priority_bus_grant, 2))
    else $error("grant taken unsynchronised");
endmodule

bind xb_master xb_master_asserts #(
  .SETTLE_CYC(SETTLE_CYC),
  .SKEW_CYC(SKEW_CYC)
) u_chk (
  .clk, .reset, .priority_bus_grant, .selection_acknowledge, .bus_busy,
  .bus_addr, .bus_ctl, .master_strobe, .slave_acknowledge,
  .interrupt_request_line,
  .data_oe_n
);

/* test/xb_host.sv */
/*
  host model: arbiter, memory slave, interrupt-taking processor.
  assumes it shares the master's clock; no reset of its own.
*/
`include "xb_consts.svh"
module xb_host (
  // clock and test controls
  input wire logic clk,
  input wire logic slow,
  input wire logic ret,
  // arbitration
  input wire logic priority_bus_request,
  input wire logic selection_acknowledge,
  input wire logic bus_busy,
  output logic priority_bus_grant,
  // transfer
  input wire logic master_strobe,
  input wire logic interrupt_request_line,
  input wire logic [`XB_ADDR_W-1:0] bus_addr,
  input wire logic [`XB_DATA_W-1:0] data_out,
  input wire logic data_oe_n,
  output logic slave_acknowledge,
  output logic [`XB_DATA_W-1:0] data_in
);
  logic [8:0] tmo = 9'h000;
  logic [3:0] cnt = 4'h0;
  logic [15:0] vec, drv, last = 16'h0;
  logic [15:0] pc = 16'h1000, processor_status_word = 16'h0007, sp = 16'h0008;
  logic [15:0] stk [0:7];
  logic drive = 1'b0;
  initial begin
    priority_bus_grant = 1'b0;
    slave_acknowledge = 1'b0;
  end
  // released lines show a pattern that changes every cycle
  assign data_in = !data_oe_n ? data_out : drive ? drv : ~last;
  always @(posedge clk) last <= data_in;
  always @(posedge clk) begin
    tmo <= priority_bus_grant ? tmo + 9'h001 : 9'h000;
    if (selection_acknowledge || tmo == 9'(`XB_GRANT_TMO_CYC)) begin
      priority_bus_grant <= 1'b0;
    end else if (priority_bus_request && !bus_busy) begin
      priority_bus_grant <= 1'b1;
    end
  end
  always @(posedge clk) begin
    cnt <= (master_strobe || interrupt_request_line) && !slave_acknowledge
      ? cnt + 4'h1 : 4'h0;
    if (master_strobe && cnt == (slow ? 4'hC : 4'h1)) begin
      slave_acknowledge <= 1'b1;
      drive <= 1'b1;
      drv <= ~bus_addr[15:0];
    end
    if (drive && !master_strobe) begin
      slave_acknowledge <= 1'b0;
      drive <= 1'b0;
    end
    if (interrupt_request_line && cnt == 4'h3) begin
      slave_acknowledge <= 1'b1;
      vec <= data_in;
    end
    if (slave_acknowledge && !drive && !interrupt_request_line
        && !bus_busy) begin
      slave_acknowledge <= 1'b0;
      stk[3'(sp - 16'h1)] <= pc;
      stk[3'(sp - 16'h2)] <= processor_status_word;
      sp <= sp - 16'h2;
      // memory holds ~address: counter at the vector, status one word up
      pc <= ~vec;
      processor_status_word <= ~(vec + 16'h0002);
    end
    if (ret) begin
      processor_status_word <= stk[3'(sp)];
      pc <= stk[3'(sp + 16'h1)];
      sp <= sp + 16'h2;
    end
  end
endmodule

/* test/tb_top.sv */
/*
  self-checking bench for the bus master against the host model.
  assumes design, package and host model are compiled first.
*/
`include "xb_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, cmd_valid, cmd_ready, rd_valid, done, slow, ret;
  logic priority_bus_request, priority_bus_grant, selection_acknowledge;
  logic bus_busy, master_strobe, slave_acknowledge, data_oe_n;
  logic interrupt_request_line;
  logic [`XB_ADDR_W-1:0] bus_addr;
  logic [`XB_CTL_W-1:0] bus_ctl;
  logic [`XB_DATA_W-1:0] rd_data, data_in, data_out;
  xb_pkg::xb_cmd_s cmd;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  xb_master u_dut (
    .clk, .reset, .cmd_valid, .cmd, .cmd_ready, .rd_data, .rd_valid,
    .done, .priority_bus_request, .priority_bus_grant,
    .selection_acknowledge, .bus_busy, .bus_busy_in(bus_busy), .bus_addr,
    .bus_ctl, .master_strobe, .slave_acknowledge, .interrupt_request_line,
    .data_in, .data_out, .data_oe_n
  );
  xb_host u_host (
    .clk, .slow, .ret, .priority_bus_request, .selection_acknowledge,
    .bus_busy, .priority_bus_grant, .master_strobe, .interrupt_request_line,
    .bus_addr, .data_out, .data_oe_n, .slave_acknowledge, .data_in
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic issue(xb_pkg::xb_kind_e k, logic [`XB_ADDR_W-1:0] a,
                       logic [7:0] n, logic [15:0] v);
    int got;
    int i;
    got = 0;
    cmd = '{k, a, n, v};
    cmd_valid = 1'b1;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(posedge clk) #1;
    @(posedge clk) #1;
    cmd_valid = 1'b0;
    for (i = 0; i < 2000 && done !== 1'b1; i++) begin
      @(posedge clk) #1;
      if (rd_valid === 1'b1) begin
        check("read word", rd_data, ~(a[15:0] + 16'(2 * got)));
        got++;
      end
    end
    check("done", 16'(done), 16'h1);
    check("words", 16'(got), k == xb_pkg::XB_KIND_INTERRUPT_REQUEST_LINE ? 16'h0 : 16'(n));
  endtask

  // back-to-back multi-word reads, prompt then slow slave
  task automatic t_reads;
    slow = 1'b0;
    issue(xb_pkg::XB_KIND_READ, 18'h00100, 8'h03, 16'h0000);
    slow = 1'b1;
    issue(xb_pkg::XB_KIND_READ, 18'h3FFFC, 8'h02, 16'h0000);
  endtask

  // interrupt, service entry and return
  task automatic t_interrupt_request_line(xb_pkg::xb_kind_e k, logic [7:0] n, logic [15:0] v);
    logic [15:0] old_pc, old_psw;
    int i;
    old_pc = u_host.pc;
    old_psw = u_host.processor_status_word;
    issue(k, 18'h00200, n, v);
    for (i = 0; i < 50 && slave_acknowledge !== 1'b0; i++) @(posedge clk) #1;
    @(posedge clk) #1;
    check("vector", u_host.vec, v);
    check("new pc", u_host.pc, ~v);
    check("new psw", u_host.processor_status_word, ~(v + 16'h0002));
    check("stacked pc", u_host.stk[7], old_pc);
    check("stacked psw", u_host.stk[6], old_psw);
    check("stack ptr", u_host.sp, 16'h0006);
    ret = 1'b1;
    @(posedge clk) #1;
    ret = 1'b0;
    check("old pc", u_host.pc, old_pc);
    check("old psw", u_host.processor_status_word, old_psw);
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    slow = 1'b0;
    ret = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reads();
    t_interrupt_request_line(xb_pkg::XB_KIND_INTERRUPT_REQUEST_LINE, 8'h00, 16'h0104);
    t_interrupt_request_line(xb_pkg::XB_KIND_READ, 8'h00, 16'h0040);
    slow = 1'b1;
    t_interrupt_request_line(xb_pkg::XB_KIND_READ_INTERRUPT_REQUEST_LINE, 8'h02, 16'h01FC);
    wrap_up();
  end
endmodule
